// File: src/pwr_wake_pkg.sv
/*
 power-down wake and retained ram protection: shared constants.
 assumes a 25 mhz reference clock and a plain register port.
*/
// Contract
// - select 00 ignores pin for power-down
// - select 01 rising, enter low, wake high
// - select 10 falling, enter high, wake low
// - select 11 any edge, never blocks, change wakes
// - lower four pins wake without enable
// - wake restarts oscillator, pulldown, clocks gated
// - delay pin low clears wake, clocks on
// - enabled interrupt runs service routine
// - disabled interrupt continues, request flag stays
// - next instruction runs before service call
// - every reset clears retained ram enable
// - enable clear freezes ram interface at once
// - frozen until software sets enable again
// - supply loss freezes ram regardless of enable
// - brief dip with enable set no freeze
// - reset switches ram to standby supply
// - isolation blocks strobes during power transients
// - only 16 kbyte portion retained
// - protected mode needs nmi low, reset exits
// - interruptible entry needs enabled pins inactive
// - reset, rtc, can, i2c also wake
package pwr_wake_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_EDGE_CFG = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_REQ = 4'h3;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
   localparam logic [15:0] EDGE_CFG_RST = 16'h0000;
   // ctrl bits
   localparam int CTRL_RAM_EN = 0;
   localparam int CTRL_PD_CFG = 1;
   // ---------------------------------------------------------------
   // edge select codes
   // ---------------------------------------------------------------
   localparam logic [1:0] SEL_OFF = 2'h0;
   localparam logic [1:0] SEL_RISE = 2'h1;
   localparam logic [1:0] SEL_FALL = 2'h2;
   localparam logic [1:0] SEL_ANY = 2'h3;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int MIN_ASSERT_NS = 40;
   localparam int MIN_ASSERT_CYC = (MIN_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_DELAY_NS = 40000;
   localparam int RC_DELAY_CYC = RC_DELAY_NS / CLK_PERIOD_NS;
   // core supply must stay low this many cycles before it counts as lost
   localparam int DIP_FILT_CYC = 2;
   // retained portion: 16 kbyte as 8k 16-bit words
   localparam int RET_ADDR_W = 13;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_PD_PROT = 2'b01,
      ST_PD_INT = 2'b10,
      ST_WAKE = 2'b11
   } pd_state_t;
endpackage

// File: src/pin_wake_det.sv
/*
 per-pin edge/level classifier for the eight fast interrupt pins.
 assumes pins already synchronised to i_ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_wake_det
   import pwr_wake_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // pin and config
   input wire logic i_pin,
   input wire logic [1:0] i_sel,
   input wire logic i_armed,
   // results
   output logic o_block,
   output logic o_wake,
   output logic o_edge
);
   typedef struct packed {
      logic prev;
      logic ref_lvl;
      logic [3:0] cnt;
   } det_t;
   det_t s_r, s_nxt;
   logic active;

   always_comb begin
      s_nxt = s_r;
      s_nxt.prev = i_pin;
      if (!i_armed) begin
         s_nxt.ref_lvl = i_pin;
      end
      active = 1'b0;
      case (i_sel)
         SEL_RISE: active = i_pin;
         SEL_FALL: active = !i_pin;
         SEL_ANY: active = (i_pin != s_r.ref_lvl);
         default: active = 1'b0;
      endcase
      // qualify for a minimum hold time
      if (active && i_armed) begin
         if (s_r.cnt < 4'(MIN_ASSERT_CYC)) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
         end
      end else begin
         s_nxt.cnt = 4'h0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // any-edge never blocks entry
   assign o_block = (i_sel == SEL_RISE && i_pin) || (i_sel == SEL_FALL && !i_pin);
   assign o_wake = (s_r.cnt >= 4'(MIN_ASSERT_CYC)) && active && i_armed;
   assign o_edge = (i_sel == SEL_RISE && i_pin && !s_r.prev)
                 || (i_sel == SEL_FALL && !i_pin && s_r.prev)
                 || (i_sel == SEL_ANY && i_pin != s_r.prev);
endmodule // pin_wake_det
`default_nettype wire

// File: src/powerdown_wake_standby_ctrl.sv
/*
 power-down entry/wake sequencing and retained ram freeze.
 assumes a plain register port on i_ref_clk; pins and analog
 comparators arrive asynchronously and are synchronised here.
*/
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module powerdown_wake_standby_ctrl
   import pwr_wake_pkg::*;
#(
   parameter int RC_CYC = RC_DELAY_CYC
)(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // cpu side
   input wire logic i_power_down_instruction,
   input wire logic i_nmi_pin,
   input wire logic [7:0] i_fast_ext_irq_pin,
   input wire logic i_rtc_irq,
   input wire logic i_can_act,
   input wire logic i_i2c_act,
   input wire logic i_core_supply_ok,
   input wire logic i_ram_en_sb,
   output logic o_pd_entered,
   output logic o_next_instr_go,
   output logic o_isr_call,
   output logic [7:0] o_irq_request_flag,
   // clocks and wake-delay pin
   input wire logic i_wake_delay_below,
   output logic o_osc_pll_en,
   output logic o_wake_delay_pulldown,
   output logic o_cpu_clk_en,
   // retained ram gate
   input wire logic [RET_ADDR_W-1:0] i_ram_addr,
   input wire logic i_ram_we_core,
   input wire logic i_ram_ce_core,
   output logic o_ram_we,
   output logic o_ram_ce,
   output logic o_ram_frozen,
   output logic o_ram_on_standby
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      pd_state_t st;
      logic [15:0] edge_cfg;
      logic ram_en;
      logic pd_cfg;
      logic [7:0] irq_en;
      logic [7:0] req;
      logic [7:0] wake_src;
      logic [16:0] rc_cnt;
      logic [15:0] rdata;
      logic isr_pend;
      logic next_go;
      logic isr_call;
      logic [10:0] s1;
      logic [10:0] s2;
      logic [3:0] dip_cnt;
   } ctl_t;
   ctl_t s_r, s_nxt;

   logic [7:0] pin_s;
   logic nmi_s, below_s, supply_s;
   logic supply_lost;
   logic [7:0] blk, wk, edg;
   logic armed;
   logic any_block, pin_wake, other_wake;

   assign pin_s = s_r.s2[7:0];
   assign nmi_s = s_r.s2[8];
   assign below_s = s_r.s2[9];
   assign supply_s = s_r.s2[10];
   assign armed = (s_r.st == ST_PD_INT);

   function automatic logic [1:0] sel_of(input logic [15:0] cfg, input int i);
      sel_of = cfg[2*i +: 2];
   endfunction

   // ---------------------------------------------------------------
   // per pin detectors
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         pin_wake_det u_det (
            .i_ref_clk(i_ref_clk),
            .i_reset_n(i_reset_n),
            .i_pin(pin_s[g]),
            .i_sel(sel_of(s_r.edge_cfg, g)),
            .i_armed(armed),
            .o_block(blk[g]),
            .o_wake(wk[g]),
            .o_edge(edg[g])
         );
      end
   endgenerate

   // lower four wake regardless of enable; upper four need it
   assign pin_wake = |(wk & {s_r.irq_en[7:4], 4'hf});
   assign any_block = |(blk & {s_r.irq_en[7:4], 4'hf});
   assign other_wake = i_rtc_irq || i_can_act || i_i2c_act;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = {i_core_supply_ok, i_wake_delay_below, i_nmi_pin, i_fast_ext_irq_pin};
      s_nxt.s2 = s_r.s1;
      if (supply_s) begin
         s_nxt.dip_cnt = 4'h0;
      end else if (s_r.dip_cnt < 4'(DIP_FILT_CYC)) begin
         s_nxt.dip_cnt = s_r.dip_cnt + 4'h1;
      end
      s_nxt.next_go = 1'b0;
      s_nxt.isr_call = s_r.isr_pend;
      s_nxt.isr_pend = 1'b0;
      s_nxt.rdata = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            ADDR_EDGE_CFG: s_nxt.rdata = s_r.edge_cfg;
            ADDR_CTRL: s_nxt.rdata = {14'h0000, s_r.pd_cfg, s_r.ram_en};
            ADDR_STATUS: s_nxt.rdata = {4'h0, o_ram_frozen, below_s, s_r.wake_src,
                                        2'(s_r.st)};
            ADDR_REQ: s_nxt.rdata = {8'h00, s_r.req};
            ADDR_IRQ_EN: s_nxt.rdata = {8'h00, s_r.irq_en};
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
      // clear first so a same-cycle edge below wins
      if (i_wr) begin
         case (i_addr)
            ADDR_EDGE_CFG: s_nxt.edge_cfg = i_wdata;
            ADDR_CTRL: begin
               s_nxt.ram_en = i_wdata[CTRL_RAM_EN];
               s_nxt.pd_cfg = i_wdata[CTRL_PD_CFG];
            end
            ADDR_REQ: s_nxt.req = s_r.req & ~i_wdata[7:0];
            ADDR_IRQ_EN: s_nxt.irq_en = i_wdata[7:0];
            default: ;
         endcase
      end
      s_nxt.req = s_nxt.req | edg;
      case (s_r.st)
         ST_RUN: begin
            if (i_power_down_instruction) begin
               if (!s_r.pd_cfg && !nmi_s) begin
                  s_nxt.st = ST_PD_PROT;
               end else if (s_r.pd_cfg && !any_block) begin
                  s_nxt.st = ST_PD_INT;
                  s_nxt.wake_src = 8'h00;
               end else begin
                  s_nxt.next_go = 1'b1;
               end
            end
         end
         ST_PD_PROT: ; // left only by reset
         ST_PD_INT: begin
            if (pin_wake || other_wake) begin
               s_nxt.st = ST_WAKE;
               s_nxt.wake_src = wk;
               s_nxt.req = s_nxt.req | wk;
               s_nxt.rc_cnt = 17'h00000;
            end
         end
         ST_WAKE: begin
            if (s_r.rc_cnt < 17'(RC_CYC)) begin
               s_nxt.rc_cnt = s_r.rc_cnt + 17'h00001;
            end else if (below_s) begin
               s_nxt.st = ST_RUN;
               s_nxt.next_go = 1'b1;
               s_nxt.isr_pend = |(s_r.wake_src & s_r.irq_en);
            end
         end
         default: s_nxt.st = ST_RUN;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_rdata = s_r.rdata;
   assign o_pd_entered = (s_r.st == ST_PD_PROT) || (s_r.st == ST_PD_INT);
   assign o_osc_pll_en = (s_r.st == ST_RUN) || (s_r.st == ST_WAKE);
   assign o_wake_delay_pulldown = (s_r.st == ST_WAKE);
   assign o_cpu_clk_en = (s_r.st == ST_RUN);
   assign o_next_instr_go = s_r.next_go;
   assign o_isr_call = s_r.isr_call;
   assign o_irq_request_flag = s_r.req;
   // a dip shorter than the filter leaves the ram open; a longer loss freezes
   // it whatever the enable holds, at the cost of a two-cycle late freeze
   assign supply_lost = !supply_s && (s_r.dip_cnt >= 4'(DIP_FILT_CYC));
   assign o_ram_frozen = !s_r.ram_en || !i_ram_en_sb || supply_lost;
   assign o_ram_on_standby = !i_reset_n || !s_r.ram_en;
   assign o_ram_we = i_ram_we_core && !o_ram_frozen;
   assign o_ram_ce = i_ram_ce_core && !o_ram_frozen && (i_ram_addr <= {RET_ADDR_W{1'b1}});

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_freeze_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      !s_r.ram_en |-> !o_ram_we && !o_ram_ce) else $error("ram strobe while frozen");
   a_reset_clears: assert property (@(posedge i_ref_clk)
      !i_reset_n |=> !s_r.ram_en) else $error("ram enable survived reset");
   a_clk_gated_wake: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_r.st == ST_WAKE |-> !o_cpu_clk_en && o_osc_pll_en) else $error("clock during wake");
   a_wake_exit: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_r.st == ST_WAKE && s_nxt.st == ST_RUN |-> below_s && s_r.rc_cnt == 17'(RC_CYC))
      else $error("early wake exit");
   a_isr_after_next: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_r.isr_pend |-> $past(s_nxt.next_go) ##1 o_isr_call) else $error("isr order");
   a_prot_stays: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_r.st == ST_PD_PROT |=> s_r.st == ST_PD_PROT) else $error("protected exit");
   a_entry_blocked: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_r.st == ST_RUN && s_nxt.st == ST_PD_INT |-> !any_block) else $error("bad entry");
   a_req_kept: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      s_r.req[0] && !(i_wr && i_addr == ADDR_REQ) |=> s_r.req[0]) else $error("flag lost");
endmodule // powerdown_wake_standby_ctrl
`default_nettype wire

// File: sim/pwr_wake_partner.sv
/*
 rc network on the wake-delay pin, seen through its threshold comparator.
 assumes the pull-down request is a level on i_ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pwr_wake_partner (
   // clock and control
   input wire logic i_ref_clk,
   input wire logic i_pulldown,
   input wire logic i_slow,
   // comparator
   output logic o_below
);
   int cnt = 0;
   // ---------------------------------------------------------------
   // capacitor discharge
   // ---------------------------------------------------------------
   // pin recharges at once when the pull-down lets go
   always @(posedge i_ref_clk) begin
      if (i_pulldown)
         cnt <= cnt + 1;
      else
         cnt <= 0;
   end
   assign o_below = cnt >= (i_slow ? 40 : 3);
endmodule // pwr_wake_partner
`default_nettype wire

// File: sim/tb_powerdown_wake_standby_ctrl.sv
/*
 self-checking bench for the power-down wake and retained ram block.
 assumes the partner rc model and a 25 mhz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_powerdown_wake_standby_ctrl;
   import pwr_wake_pkg::*;
   logic i_ref_clk = 0, i_reset_n = 0, i_wr = 0, i_rd = 0, i_power_down_instruction = 0;
   logic i_nmi_pin = 1, i_rtc_irq = 0, i_can_act = 0, i_i2c_act = 0, i_core_supply_ok = 1;
   logic i_ram_en_sb = 1, i_ram_we_core = 0, i_ram_ce_core = 0, i_wake_delay_below, slow = 0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, o_rdata, r;
   logic [7:0] i_fast_ext_irq_pin = 8'h00, o_irq_request_flag;
   logic [RET_ADDR_W-1:0] i_ram_addr = '0;
   logic o_pd_entered, o_next_instr_go, o_isr_call, o_osc_pll_en, o_wake_delay_pulldown;
   logic o_cpu_clk_en, o_ram_we, o_ram_ce, o_ram_frozen, o_ram_on_standby, go_d;
   int n_mismatch = 0, n_checks = 0, n_go = 0, n_isr = 0, g, w;
   // ---------------------------------------------------------------
   // design, partner, clock
   // ---------------------------------------------------------------
   powerdown_wake_standby_ctrl #(.RC_CYC(4)) powerdown_wake_standby_ctrl_i (.*);
   pwr_wake_partner pwr_wake_partner_i (.i_ref_clk(i_ref_clk),
      .i_pulldown(o_wake_delay_pulldown), .i_slow(slow), .o_below(i_wake_delay_below));
   initial begin
      forever #20 i_ref_clk = ~i_ref_clk;
   end
   // pulse counters; service call must trail the resume pulse by one cycle
   always @(posedge i_ref_clk) begin
      go_d <= o_next_instr_go;
      if (o_next_instr_go === 1'b1) n_go++;
      if (o_isr_call === 1'b1) begin
         n_isr++;
         `CHK(go_d, 1'b1)
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      `CHK(o_rdata, e)
   endtask
   // bounded wait on pull-down (0) or cpu clock enable (1)
   task automatic wait_for(input int w, input int lim);
      int k;
      k = 0;
      while ((w ? o_cpu_clk_en : o_wake_delay_pulldown) !== 1'b1 && k < lim) begin
         @(negedge i_ref_clk);
         k++;
      end
      if (k >= lim) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         give_verdict();
      end
   endtask
   task automatic enter_pd;
      @(posedge i_ref_clk);
      i_power_down_instruction <= 1'b1;
      @(posedge i_ref_clk);
      i_power_down_instruction <= 1'b0;
      cyc(2);
      @(negedge i_ref_clk);
   endtask
   task automatic wake_seq(input int isr);
      int g0, i0;
      g0 = n_go;
      i0 = n_isr;
      wait_for(0, 100);
      `CHK(o_cpu_clk_en, 1'b0)
      `CHK(o_osc_pll_en, 1'b1)
      wait_for(1, 200);
      cyc(3);
      @(negedge i_ref_clk);
      `CHK(n_go - g0, 1)
      `CHK(n_isr - i0, isr)
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(72));
      cyc(4);
      i_reset_n <= 1'b1;
      chk_rd(ADDR_EDGE_CFG, EDGE_CFG_RST);
      chk_rd(ADDR_CTRL, 16'h0000);
      chk_rd(ADDR_STATUS, 16'h0800);
      r = 16'($urandom());
      wr(ADDR_EDGE_CFG, r);
      chk_rd(ADDR_EDGE_CFG, r);
      chk_rd(4'hf, 16'h0000);
      @(posedge i_ref_clk);
      i_ram_addr <= RET_ADDR_W'($urandom());
      i_ram_we_core <= 1'b1;
      i_ram_ce_core <= 1'b1;
      @(negedge i_ref_clk);
      `CHK({o_ram_frozen, o_ram_we}, 2'b10)
      wr(ADDR_CTRL, 16'h0001);
      @(negedge i_ref_clk);
      `CHK({o_ram_we, o_ram_ce}, 2'b11)
      // one-cycle dip with enable set: ram stays open
      @(posedge i_ref_clk);
      i_core_supply_ok <= 1'b0;
      @(posedge i_ref_clk);
      i_core_supply_ok <= 1'b1;
      repeat (4) begin
         @(negedge i_ref_clk);
         `CHK(o_ram_we, 1'b1)
      end
      @(posedge i_ref_clk);
      i_core_supply_ok <= 1'b0;
      cyc(4);
      @(negedge i_ref_clk);
      `CHK(o_ram_we, 1'b0)
      @(posedge i_ref_clk);
      i_core_supply_ok <= 1'b1;
      wr(ADDR_CTRL, 16'h0000);
      @(negedge i_ref_clk);
      `CHK({o_ram_frozen, o_ram_we}, 2'b10)
      $display("test ram_gate done");
      // entry gating: every select code against both pin levels
      wr(ADDR_CTRL, 16'h0003);
      for (int s = 0; s < 4; s++) begin
         for (int l = 0; l < 2; l++) begin
            wr(ADDR_EDGE_CFG, 16'(s));
            i_fast_ext_irq_pin <= 8'(l);
            slow <= l[0];
            cyc(4);
            g = n_go;
            enter_pd();
            `CHK(o_pd_entered, !((s == 1 && l == 1) || (s == 2 && l == 0)))
            if (o_pd_entered === 1'b1) begin
               @(posedge i_ref_clk);
               w = $urandom_range(2);
               i_rtc_irq <= (w == 0);
               i_can_act <= (w == 1);
               i_i2c_act <= (w == 2);
               wake_seq(0);
               @(posedge i_ref_clk);
               i_rtc_irq <= 1'b0;
               i_can_act <= 1'b0;
               i_i2c_act <= 1'b0;
            end else begin
               `CHK(n_go - g, 1)
            end
         end
      end
      $display("test entry_gating done");
      // pin wake of a lower pin with its enable clear
      for (int k = 0; k < 4; k++) begin
         @(posedge i_ref_clk);
         i_fast_ext_irq_pin <= 8'(k == 1);
         cyc(4);
         wr(ADDR_EDGE_CFG, 16'(k < 2 ? k + 1 : 3));
         wr(ADDR_REQ, 16'h00ff);
         enter_pd();
         `CHK(o_pd_entered, 1'b1)
         @(posedge i_ref_clk);
         i_fast_ext_irq_pin <= 8'(k != 1);
         wake_seq(0);
         `CHK(o_irq_request_flag[0], 1'b1)
      end
      wr(ADDR_REQ, 16'h0001);
      @(negedge i_ref_clk);
      `CHK(o_irq_request_flag[0], 1'b0)
      // upper pin, enabled: service routine follows resume
      wr(ADDR_IRQ_EN, 16'h0010);
      wr(ADDR_EDGE_CFG, 16'h0100);
      i_fast_ext_irq_pin <= 8'h00;
      cyc(4);
      enter_pd();
      @(posedge i_ref_clk);
      i_fast_ext_irq_pin <= 8'h10;
      wake_seq(1);
      chk_rd(ADDR_STATUS, 16'h0040);
      $display("test pin_wake done");
      // protected mode: refused with nmi high, deaf to wake sources
      wr(ADDR_CTRL, 16'h0001);
      wr(ADDR_EDGE_CFG, 16'h0003);
      i_fast_ext_irq_pin <= 8'h00;
      cyc(4);
      enter_pd();
      `CHK(o_pd_entered, 1'b0)
      @(posedge i_ref_clk);
      i_nmi_pin <= 1'b0;
      cyc(4);
      enter_pd();
      `CHK(o_pd_entered, 1'b1)
      @(posedge i_ref_clk);
      i_fast_ext_irq_pin <= 8'h01;
      i_rtc_irq <= 1'b1;
      cyc(30);
      @(negedge i_ref_clk);
      `CHK({o_pd_entered, o_cpu_clk_en}, 2'b10)
      // standby: reset first, then the supply goes
      @(posedge i_ref_clk);
      i_reset_n <= 1'b0;
      cyc(1);
      i_core_supply_ok <= 1'b0;
      cyc(3);
      @(negedge i_ref_clk);
      `CHK({o_ram_on_standby, o_ram_frozen, o_ram_we}, 3'b110)
      @(posedge i_ref_clk);
      i_core_supply_ok <= 1'b1;
      i_rtc_irq <= 1'b0;
      i_nmi_pin <= 1'b1;
      cyc(3);
      i_reset_n <= 1'b1;
      chk_rd(ADDR_CTRL, 16'h0000);
      `CHK({o_cpu_clk_en, o_ram_frozen}, 2'b11)
      $display("test protected_standby done");
      give_verdict();
   end
endmodule // tb_powerdown_wake_standby_ctrl
`default_nettype wire
